// ==== design/epc_defs.vh ====
`ifndef EPC_DEFS_VH
`define EPC_DEFS_VH

// Byte offset of the interrupt control and state register.
`define EPC_ICS_OFF 12'hD04
`define EPC_ADDR_W 12

// Field positions inside the interrupt control and state register.
`define EPC_DSV_SET_BIT 28
`define EPC_DSV_CLR_BIT 27
`define EPC_TICK_SET_BIT 26
`define EPC_TICK_CLR_BIT 25
`define EPC_RSV24_BIT 24
`define EPC_HALT_IRQ_BIT 23
`define EPC_ANY_IRQ_BIT 22
`define EPC_RSV_LO_MSB 21
`define EPC_RSV_LO_LSB 18

// Reset values.
`define EPC_ICS_RESET 32'h00000000
`define EPC_PEND_RESET 1'b0

// Number of ordinary interrupt lines.
`define EPC_NUM_IRQ 44

`endif

// ==== design/epc_pend_bit.v ====
`timescale 1ns/1ps
// One sticky pending flag; a set in the same cycle as a clear wins.
module epc_pend_bit (
  input wire pclk, // Processor clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire set_i, // Set request, one-cycle pulse.
  input wire clr_i, // Clear request, one-cycle pulse.
  output wire pend_o // Pending state.
);
`include "epc_defs.vh"

  reg pend_q;
  reg pend_d;

  always @* begin
    pend_d = pend_q;
    if (clr_i) begin
      pend_d = 1'b0;
    end
    // A set arriving together with a clear is not lost.
    if (set_i) begin
      pend_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= `EPC_PEND_RESET;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pend_o = pend_q;

endmodule // epc_pend_bit

// ==== design/epc_irq_reduce.v ====
`timescale 1ns/1ps
`include "epc_defs.vh"
// Collapses the per-line pending vector into a single flag.
module epc_irq_reduce #(
  parameter NUM_IRQ = `EPC_NUM_IRQ
) (
  input wire [NUM_IRQ-1:0] irq_pend_i, // Pending flags of ordinary interrupts.
  output wire any_o // High while at least one line is pending.
);

  wire [NUM_IRQ:0] chain;

  assign chain[0] = 1'b0;

  genvar i;
  generate
    for (i = 0; i < NUM_IRQ; i = i + 1) begin : g_or
      assign chain[i+1] = chain[i] | irq_pend_i[i];
    end
  endgenerate

  assign any_o = chain[NUM_IRQ];

endmodule // epc_irq_reduce

// ==== design/epc_top.v ====
`timescale 1ns/1ps
`include "epc_defs.vh"
// Contract
// - Bit 28 reads 1 while the deferred-service exception is pending.
// - Writing 1 to bit 28 makes it pending; writing 0 changes nothing.
// - Only a software write of 1 sets deferred-service pending.
// - Writing 1 to bit 27 clears deferred-service pending; 0 has no effect.
// - Bits 27 and 25 are write-only; their read value is meaningless.
// - Bit 26 reads 1 while the system tick exception is pending.
// - Writing 1 to bit 26 makes the tick pending; 0 has no effect.
// - Writing 1 to bit 25 clears tick pending; 0 has no effect.
// - Bit 23 reads 1 when leaving debug halt will take an interrupt.
// - Bit 23 reads zero whenever the processor is not in debug mode.
// - Bit 22 reads 1 when any interrupt is pending.
// - Bit 22 ignores the non-maskable interrupt and all faults.
// - Reserved bits 24 and 21:18 read zero; software preserves them.
module epc_top #(
  parameter NUM_IRQ = `EPC_NUM_IRQ
) (
  input wire pclk, // Processor clock, 125 MHz.
  input wire presetn, // Asynchronous reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB access phase.
  input wire pwrite, // APB direction, high for write.
  input wire [`EPC_ADDR_W-1:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  input wire [3:0] pstrb, // APB write byte strobes.
  input wire [2:0] pprot, // APB protection; bit 0 marks privileged.
  output wire [31:0] prdata, // APB read data.
  output wire pready, // APB ready.
  output wire pslverr, // APB error.
  input wire [NUM_IRQ-1:0] irq_pend, // Pending flags of ordinary interrupts.
  input wire tick_event, // System timer event, one-cycle pulse.
  input wire dbg_halted, // Processor is halted in debug mode.
  input wire halt_irq_masked, // Interrupts are masked for the release from halt.
  input wire deferred_service_ack, // Core entered the deferred-service handler.
  input wire system_tick_ack, // Core entered the system tick handler.
  output wire deferred_service_pending, // Deferred-service exception pending.
  output wire system_tick_pending, // System tick exception pending.
  output wire any_irq_pending // Any ordinary interrupt pending.
);

  // Bus phase decode.
  wire setup_ph;
  wire access_ph;
  wire hit;
  wire priv_ok;
  wire full_word;
  wire acc_ok;
  wire wr_take;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit = (paddr == `EPC_ICS_OFF);
  assign priv_ok = pprot[0];
  // Only aligned whole-word writes are accepted; partial writes are refused.
  assign full_word = ~pwrite | (pstrb == 4'hF);
  assign acc_ok = hit & priv_ok & full_word;
  assign pready = 1'b1;
  assign wr_take = access_ph & pwrite & pready & acc_ok;

  // Pending state machinery.
  wire dsv_pend;
  wire tick_pend;
  wire any_irq;
  wire dsv_set;
  wire dsv_clr;
  wire tick_set;
  wire tick_clr;

  assign dsv_set = wr_take & pwdata[`EPC_DSV_SET_BIT];
  assign dsv_clr = (wr_take & pwdata[`EPC_DSV_CLR_BIT]) | deferred_service_ack;
  assign tick_set = (wr_take & pwdata[`EPC_TICK_SET_BIT]) | tick_event;
  assign tick_clr = (wr_take & pwdata[`EPC_TICK_CLR_BIT]) | system_tick_ack;

  // Set beats clear inside each flag, so a doubled write still ends pending.
  epc_pend_bit u_dsv (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(dsv_set),
    .clr_i(dsv_clr),
    .pend_o(dsv_pend)
  );

  epc_pend_bit u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(tick_set),
    .clr_i(tick_clr),
    .pend_o(tick_pend)
  );

  epc_irq_reduce #(
    .NUM_IRQ(NUM_IRQ)
  ) u_any (
    .irq_pend_i(irq_pend),
    .any_o(any_irq)
  );

  // Read value assembly.
  wire halt_takes;
  reg [31:0] rd_val;

  assign halt_takes = dbg_halted & ~halt_irq_masked & (any_irq | dsv_pend | tick_pend);

  always @* begin
    rd_val = `EPC_ICS_RESET;
    rd_val[`EPC_DSV_SET_BIT] = dsv_pend;
    rd_val[`EPC_TICK_SET_BIT] = tick_pend;
    rd_val[`EPC_DSV_CLR_BIT] = 1'b0;
    rd_val[`EPC_TICK_CLR_BIT] = 1'b0;
    rd_val[`EPC_RSV24_BIT] = 1'b0;
    rd_val[`EPC_RSV_LO_MSB:`EPC_RSV_LO_LSB] = 4'h0;
    rd_val[`EPC_HALT_IRQ_BIT] = halt_takes;
    rd_val[`EPC_ANY_IRQ_BIT] = any_irq;
  end

  // Read data and error are captured in the setup phase and held for access.
  reg [31:0] prdata_q;
  reg pslverr_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      pslverr_q <= ~acc_ok;
      if (!pwrite && acc_ok) begin
        prdata_q <= rd_val;
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q & access_ph;

  assign deferred_service_pending = dsv_pend;
  assign system_tick_pending = tick_pend;
  assign any_irq_pending = any_irq;

endmodule // epc_top

// ==== test/epc_asserts.sv ====
`timescale 1ns/1ps
`include "epc_defs.vh"
module epc_asserts #(
  parameter NUM_IRQ = `EPC_NUM_IRQ
) (
  input wire pclk, // Clock.
  input wire presetn, // Reset.
  input wire psel, // Bus.
  input wire penable, // Bus.
  input wire pwrite, // Bus.
  input wire [`EPC_ADDR_W-1:0] paddr, // Bus.
  input wire [31:0] pwdata, // Bus.
  input wire [3:0] pstrb, // Bus.
  input wire [2:0] pprot, // Bus.
  input wire [31:0] prdata, // Bus.
  input wire [NUM_IRQ-1:0] irq_pend, // Lines.
  input wire tick_event, // Timer.
  input wire dbg_halted, // Halt.
  input wire deferred_service_pending, // Flag.
  input wire system_tick_pending, // Flag.
  input wire any_irq_pending // Flag.
);
  wire ok = psel && penable && paddr == `EPC_ICS_OFF && pprot[0];
  wire wr = ok && pwrite && pstrb == 4'hF;
  wire rd = ok && !pwrite;
  wire dsv_w = wr && pwdata[28];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dsv_set: assert property (dsv_w |=> deferred_service_pending)
    else $error("dsv set lost");
  a_dsv_clr: assert property (wr && pwdata[27] && !pwdata[28] |=> !deferred_service_pending)
    else $error("dsv clear lost");
  a_dsv_hw: assert property ($rose(deferred_service_pending) |-> $past(dsv_w))
    else $error("dsv set by hardware");
  a_tick_set: assert property (wr && pwdata[26] || tick_event |=> system_tick_pending)
    else $error("tick set lost");
  a_tick_clr: assert property (wr && pwdata[25] && !pwdata[26] && !tick_event
    |=> !system_tick_pending) else $error("tick clear lost");
  a_any_irq: assert property (any_irq_pending == |irq_pend)
    else $error("any flag wrong");
  a_rd_pend: assert property (rd |-> prdata[28] == $past(deferred_service_pending)
    && prdata[26] == $past(system_tick_pending)) else $error("pend read wrong");
  a_rd_any: assert property (rd |-> prdata[22] == $past(any_irq_pending))
    else $error("any read wrong");
  a_halt_off: assert property (rd && !$past(dbg_halted) |-> !prdata[23])
    else $error("halt bit set");
  a_rsv_zero: assert property (rd |-> !prdata[24] && prdata[21:18] == 4'h0)
    else $error("reserved set");
  cover property (dsv_w);
  cover property (tick_event);
  cover property (rd && prdata[23]);
endmodule // epc_asserts
bind epc_top epc_asserts #(.NUM_IRQ(NUM_IRQ)) chk_u (.*);

// ==== test/exception_pend_control_bits_bench.sv ====
`timescale 1ns/1ps
`include "epc_defs.vh"
module exception_pend_control_bits_bench;
  reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg tick_event = 1'h0, dbg_halted = 1'h0, halt_irq_masked = 1'h0, err = 1'h0;
  reg [2:0] pprot = 3'h1;
  wire pslverr;
  reg [31:0] pwdata = 32'h0, r;
  reg [43:0] irq_pend = 44'h0;
  wire [31:0] prdata;
  wire pready;
  integer n_mismatch = 0, checked = 0, cyc = 0;
  epc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(12'hD04), .pwdata(pwdata), .pstrb(4'hF), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pend(irq_pend),
    .tick_event(tick_event), .dbg_halted(dbg_halted), .halt_irq_masked(halt_irq_masked),
    .deferred_service_ack(1'h0), .system_tick_ack(1'h0), .deferred_service_pending(),
    .system_tick_pending(), .any_irq_pending());
  initial forever #4 pclk = ~pclk;
  task results; begin
    $display("n_mismatch=%0d checked=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  task apb(input w, input [31:0] d); begin
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  end endtask
  // Write-only clear bits are masked out of every read.
  task chk(input [31:0] e); begin
    apb(1'h0, 32'h0);
    checked = checked + 1;
    if ((r & 32'hF5FFFFFF) !== e || err !== 1'h0) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t read %h want %h err %b", $time, r, e, err);
    end
  end endtask
  // An unprivileged write must be refused and leave the flag alone.
  task t_err; begin
    pprot <= 3'h0;
    apb(1'h1, 32'h10000000);
    checked = checked + 1;
    if (err !== 1'h1) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t unprivileged write not refused", $time);
    end
    pprot <= 3'h1;
    chk(32'h0);
    $display("err done");
  end endtask
  task t_dsv; begin
    apb(1'h1, 32'h10000000);
    chk(32'h10000000);
    apb(1'h1, 32'h0);
    chk(32'h10000000);
    apb(1'h1, 32'h08000000);
    chk(32'h0);
    $display("dsv done");
  end endtask
  task t_tick; begin
    apb(1'h1, 32'h04000000);
    chk(32'h04000000);
    apb(1'h1, 32'h02000000);
    chk(32'h0);
    tick_event <= 1'h1;
    @(posedge pclk);
    tick_event <= 1'h0;
    chk(32'h04000000);
    apb(1'h1, 32'h02000000);
    chk(32'h0);
    $display("tick done");
  end endtask
  task t_irq; begin
    irq_pend <= 44'h80000000000;
    dbg_halted <= 1'h1;
    chk(32'h00C00000);
    halt_irq_masked <= 1'h1;
    chk(32'h00400000);
    halt_irq_masked <= 1'h0;
    dbg_halted <= 1'h0;
    chk(32'h00400000);
    irq_pend <= 44'h0;
    chk(32'h0);
    $display("irq done");
  end endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_dsv;
    t_tick;
    t_irq;
    t_err;
    results;
  end
endmodule // exception_pend_control_bits_bench
